// *** core/trace_player_pkg.sv ***
/*
  constants shared by the trace memory player and its sample ram.
  assumes a single 100 MHz clock and a synchronous, active-high reset.
*/
package trace_player_pkg;

  localparam int CLK_HZ = 100_000_000;
  localparam int RASTER_HZ = 50_000_000;
  localparam int RASTER_DIV = CLK_HZ / RASTER_HZ;

  localparam int BASE_DEPTH = 131072;
  localparam int LARGE_DEPTH = 524288;
  localparam int DIR_SLOTS = 50;
  localparam int FN_POINTS = 4096;
  localparam int COPY_FN_POINTS = 8192;

  localparam int POINT_W = 16;
  localparam int AMP_W = 12;
  localparam logic [11:0] AMP_MIN = 12'h001;
  localparam logic [11:0] AMP_MID = 12'h800;
  localparam logic [11:0] AMP_MAX = 12'hFFF;

  // marker bit positions inside a point
  localparam int ZAXIS_BIT = 12;
  localparam int TRIG_BIT = 13;
  localparam int POS_BIT = 14;
  localparam int START_BIT = 15;

  localparam logic [3:0] OP_DEF_SIZE = 4'h1;
  localparam logic [3:0] OP_DEF_COPY_REC = 4'h2;
  localparam logic [3:0] OP_DEF_COPY_FN = 4'h3;
  localparam logic [3:0] OP_WR_POINT = 4'h4;
  localparam logic [3:0] OP_DELETE = 4'h5;
  localparam logic [3:0] OP_RESIZE = 4'h6;
  localparam logic [3:0] OP_SEL_USER = 4'h7;
  localparam logic [3:0] OP_SEL_FN = 4'h8;
  localparam logic [3:0] OP_SYNC_SRC = 4'h9;
  localparam logic [3:0] OP_FILTER = 4'hA;

  localparam logic [1:0] SHAPE_SINE = 2'h0;
  localparam logic [1:0] SHAPE_SQUARE = 2'h1;
  localparam logic [1:0] SHAPE_RAMP = 2'h2;
  localparam logic [1:0] SHAPE_TRIANGLE = 2'h3;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_FILL = 6'b00_0010,
    ST_RD = 6'b00_0100,
    ST_WR = 6'b00_1000,
    ST_GEN = 6'b01_0000,
    ST_SPARE = 6'b10_0000
  } eng_state_t;

endpackage : trace_player_pkg

// *** core/trace_ram.sv ***
/*
  sample memory: one write port and two registered read ports.
  assumes addresses in range; read data appears one clock after the address.
*/
`timescale 1ns/100ps
module trace_ram
  import trace_player_pkg::*;
#(
  parameter int DEPTH = BASE_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [POINT_W-1:0] wrData,
  input wire logic [AW-1:0] rdAddrA,
  output logic [POINT_W-1:0] rdDataA,
  input wire logic [AW-1:0] rdAddrB,
  output logic [POINT_W-1:0] rdDataB
);

  typedef struct packed {
    logic [POINT_W-1:0] a;
    logic [POINT_W-1:0] b;
  } ram_t;

  logic [POINT_W-1:0] mem [DEPTH];
  ram_t r_reg;
  ram_t r_next;

  // no reset on the array: contents are defined by the engine after reset
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_comb begin
    r_next = r_reg;
    r_next.a = mem[rdAddrA];
    r_next.b = mem[rdAddrB];
  end

  always_ff @(posedge clk) begin
    r_reg <= r_next;
  end

  assign rdDataA = r_reg.a;
  assign rdDataB = r_reg.b;

endmodule : trace_ram

// *** core/trace_memory_raster_player.sv ***
/*
  waveform trace memory with record allocator, builtin function generator
  and sequential / phase accumulate playback.
  assumes a command processor that waits for cmdReady and sends legal names.
*/
// What this block does
// R1 - memory holds 131,072 points, parameter allows 524,288
// R2 - each point is 16 bits: 12 amplitude, four marker bits
// R3 - amplitude code 001 min, 800 midpoint, FFF max, passed unchanged
// R4 - builtin function samples go to top 4K points unless space lacks
// R5 - builtin functions play by phase accumulator at programmed frequency word
// R6 - sequential playback steps one point per sample tick, each held once
// R7 - repetition rate is sample rate divided by record point count
// R8 - first record starts at address zero
// R9 - next records follow directly, used space contiguous from bottom
// R10 - delete or resize moves later records to keep layout contiguous
// R11 - at most 50 records, refuse new record when memory is full
// R12 - controller supplies names up to 12 chars, letter first
// R13 - copy of a record takes the source record's size
// R14 - copy of a builtin function gets 8192 points
// R15 - sized record without data reads midscale 800 everywhere
// R16 - selecting a record sets sequential mode, marker sync, filter off
// R17 - sample clock defaults to 50 MHz in sequential mode; phase mode takes a sample every 100 MHz clock
// R18 - after reset: no records, sine in top 4K, phase mode, filter on
// R19 - records addressed by relative index, absolute placement hidden
// R20 - writing point zero clears start marker; sync re-select restores it
// R21 - bit 12 intensity, bit 13 intermodule trigger flag
// R22 - marker bits output in the same cycle as amplitude
`timescale 1ns/100ps
module trace_memory_raster_player
  import trace_player_pkg::*;
#(
  parameter int DEPTH = BASE_DEPTH,
  parameter int SLOTS = DIR_SLOTS,
  parameter int SAMPLE_DIV = RASTER_DIV
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [3:0] cmdOp,
  input wire logic [5:0] cmdSlot,
  input wire logic [5:0] cmdSrc,
  input wire logic [$clog2(DEPTH):0] cmdSize,
  input wire logic [$clog2(DEPTH)-1:0] cmdIndex,
  input wire logic [POINT_W-1:0] cmdData,
  output logic cmdDone,
  output logic cmdError,
  input wire logic [31:0] cwFreqWord,
  output logic [AMP_W-1:0] sampleCode,
  output logic [3:0] markerOut,
  output logic syncOut,
  output logic sequentialPlaybackMode,
  output logic startMarkerSyncSource,
  output logic filterEnable,
  output logic [$clog2(DEPTH):0] usedPoints
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_V = (AW+1)'(DEPTH); // [R1]
  localparam logic [AW:0] FN_PTS = (AW+1)'(FN_POINTS);
  localparam logic [AW-1:0] FN_BASE = AW'(DEPTH - FN_POINTS); // [R4]
  localparam logic [15:0] DIV_LAST = 16'(SAMPLE_DIV - 1);

  typedef struct packed {
    eng_state_t st;
    logic [AW-1:0] src;
    logic [AW-1:0] dst;
    logic [AW:0] cnt;
    logic down;
    logic setMark;
    logic [AW-1:0] fillAddr;
    logic [AW:0] fillCnt;
    logic fillMark;
    logic [AW:0] genIdx;
    logic [1:0] genShape;
    logic genHalf;
    logic [SLOTS-1:0][AW-1:0] dStart;
    logic [SLOTS-1:0][AW:0] dSize;
    logic [SLOTS-1:0] dValid;
    logic [AW:0] used;
    logic seq;
    logic syncMk;
    logic filt;
    logic [5:0] sel;
    logic [AW:0] playIdx;
    logic [15:0] div;
    logic [31:0] phase;
    logic tickD;
    logic [AMP_W-1:0] amp;
    logic [3:0] mark;
    logic sync;
    logic done;
    logic err;
  } core_t;

  core_t r_reg;
  core_t r_next;

  logic wrEn;
  logic [AW-1:0] wrAddr;
  logic [POINT_W-1:0] wrData;
  logic [AW-1:0] engAddr;
  logic [AW-1:0] playAddr;
  logic [POINT_W-1:0] engData;
  logic [POINT_W-1:0] playData;

  trace_ram #(.DEPTH(DEPTH), .AW(AW)) ram (
    .clk(clk),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .rdAddrA(engAddr),
    .rdDataA(engData),
    .rdAddrB(playAddr),
    .rdDataB(playData)
  );

  // shapes are kept to cheap closed forms so no table rom is needed
  function automatic logic [AMP_W-1:0] shape_val(input logic [1:0] shape, input logic [11:0] p);
    logic [21:0] prod;
    logic [11:0] v;
    prod = 22'(p[10:0]) * (22'd2048 - 22'(p[10:0]));
    v = (prod[21:9] > 13'd2047) ? 12'd2047 : prod[20:9];
    case (shape)
      SHAPE_SINE: shape_val = p[11] ? AMP_MID - v : AMP_MID + v;
      SHAPE_SQUARE: shape_val = p[11] ? AMP_MIN : AMP_MAX;
      SHAPE_RAMP: shape_val = (p == 12'h000) ? AMP_MIN : p;
      default: shape_val = p[11] ? AMP_MAX - {p[10:0], 1'b0} : AMP_MIN + {p[10:0], 1'b0};
    endcase
  endfunction : shape_val

  always_comb begin
    logic [AW:0] newSize;
    logic [AW:0] oldSize;
    logic [AW:0] oldEnd;
    logic [AW:0] tail;
    logic [AW+1:0] chk;
    logic [AW:0] diff;
    logic [5:0] k;
    logic tick;
    logic [11:0] p;
    newSize = '0;
    oldSize = '0;
    oldEnd = '0;
    tail = '0;
    chk = '0;
    diff = '0;
    k = cmdSlot;
    tick = 1'b0;
    p = '0;
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.err = 1'b0;
    wrEn = 1'b0;
    wrAddr = r_reg.dst;
    wrData = '0;
    engAddr = r_reg.src;
    case (r_reg.st)
      ST_IDLE: begin
        if (cmdValid) begin
          r_next.err = 1'b1;
          case (cmdOp)
            OP_DEF_SIZE, OP_DEF_COPY_REC, OP_DEF_COPY_FN: begin
              if (cmdOp == OP_DEF_COPY_REC) begin
                newSize = (cmdSrc < SLOTS && r_reg.dValid[cmdSrc]) ? r_reg.dSize[cmdSrc] : '0; // [R13]
              end else if (cmdOp == OP_DEF_COPY_FN) begin
                newSize = (AW+1)'(COPY_FN_POINTS); // [R14]
              end else begin
                newSize = cmdSize;
              end
              // slot limit and a full memory both refuse the define
              if (k < SLOTS && !r_reg.dValid[k] && newSize != '0
                  && newSize <= DEPTH_V - r_reg.used) begin // [R11]
                r_next.err = 1'b0;
                r_next.dValid[k] = 1'b1;
                r_next.dStart[k] = r_reg.used[AW-1:0]; // [R8] [R9]
                r_next.dSize[k] = newSize;
                r_next.used = r_reg.used + newSize;
                r_next.dst = r_reg.used[AW-1:0];
                r_next.cnt = newSize;
                r_next.fillCnt = '0;
                if (cmdOp == OP_DEF_COPY_REC) begin
                  r_next.src = r_reg.dStart[cmdSrc];
                  r_next.down = 1'b0;
                  r_next.setMark = 1'b0;
                  r_next.st = ST_RD;
                end else if (cmdOp == OP_DEF_COPY_FN) begin
                  r_next.genIdx = '0;
                  r_next.genHalf = 1'b1;
                  r_next.genShape = cmdSrc[1:0];
                  r_next.st = ST_GEN;
                end else begin
                  r_next.fillAddr = r_reg.used[AW-1:0];
                  r_next.fillCnt = newSize;
                  r_next.fillMark = 1'b1;
                  r_next.st = ST_FILL; // [R15]
                end
              end
            end
            OP_WR_POINT: begin
              if (k < SLOTS && r_reg.dValid[k] && {1'b0, cmdIndex} < r_reg.dSize[k]) begin
                r_next.err = 1'b0;
                r_next.done = 1'b1;
                wrEn = 1'b1;
                wrAddr = r_reg.dStart[k] + cmdIndex; // [R19]
                wrData = cmdData; // [R2]
                if (cmdIndex == '0) begin
                  wrData[START_BIT] = 1'b0; // [R20]
                end
              end
            end
            OP_DELETE, OP_RESIZE: begin
              newSize = (cmdOp == OP_DELETE) ? '0 : cmdSize;
              if (k < SLOTS && r_reg.dValid[k]) begin
                oldSize = r_reg.dSize[k];
                oldEnd = {1'b0, r_reg.dStart[k]} + oldSize;
                tail = r_reg.used - oldEnd;
                diff = newSize - oldSize;
                chk = {1'b0, r_reg.used} + {1'b0, newSize} - {1'b0, oldSize};
                if ((cmdOp == OP_DELETE || newSize != '0) && chk <= {1'b0, DEPTH_V}) begin
                  r_next.err = 1'b0;
                  for (int j = 0; j < SLOTS; j++) begin
                    if (r_reg.dValid[j] && r_reg.dStart[j] > r_reg.dStart[k]) begin
                      r_next.dStart[j] = r_reg.dStart[j] + diff[AW-1:0]; // [R10]
                    end
                  end
                  r_next.dSize[k] = newSize;
                  r_next.dValid[k] = (cmdOp != OP_DELETE);
                  r_next.used = chk[AW:0];
                  r_next.fillAddr = oldEnd[AW-1:0];
                  r_next.fillCnt = (newSize > oldSize) ? diff : '0;
                  r_next.fillMark = 1'b0;
                  r_next.setMark = 1'b0;
                  r_next.cnt = tail;
                  // growing moves the tail from the top down so no point is overwritten early
                  r_next.down = (newSize > oldSize);
                  if (newSize > oldSize) begin
                    r_next.src = r_reg.used[AW-1:0] - 1'b1;
                    r_next.dst = chk[AW-1:0] - 1'b1;
                  end else begin
                    r_next.src = oldEnd[AW-1:0];
                    r_next.dst = oldEnd[AW-1:0] + diff[AW-1:0];
                  end
                  if (tail != '0) begin
                    r_next.st = ST_RD; // [R10]
                  end else if (newSize > oldSize) begin
                    r_next.st = ST_FILL;
                  end else begin
                    r_next.done = 1'b1;
                  end
                end
              end
            end
            OP_SEL_USER: begin
              if (k < SLOTS && r_reg.dValid[k]) begin
                r_next.err = 1'b0;
                r_next.seq = 1'b1; // [R16]
                r_next.syncMk = 1'b1;
                r_next.filt = 1'b0;
                r_next.sel = k;
                r_next.playIdx = '0;
                r_next.src = r_reg.dStart[k];
                r_next.dst = r_reg.dStart[k];
                r_next.cnt = (AW+1)'(1);
                r_next.down = 1'b0;
                r_next.setMark = !r_reg.syncMk;
                r_next.fillCnt = '0;
                r_next.st = ST_RD;
              end
            end
            OP_SEL_FN: begin
              if (DEPTH_V - r_reg.used >= FN_PTS) begin // [R4]
                r_next.err = 1'b0;
                r_next.seq = 1'b0; // [R5]
                r_next.dst = FN_BASE;
                r_next.cnt = FN_PTS;
                r_next.genIdx = '0;
                r_next.genHalf = 1'b0;
                r_next.genShape = cmdSrc[1:0];
                r_next.st = ST_GEN;
              end
            end
            OP_SYNC_SRC: begin
              r_next.err = 1'b0;
              r_next.syncMk = cmdData[0];
              // re-selecting marker sync rebuilds the start marker of the playing record
              if (cmdData[0] && !r_reg.syncMk && r_reg.seq && r_reg.dValid[r_reg.sel]) begin
                r_next.src = r_reg.dStart[r_reg.sel];
                r_next.dst = r_reg.dStart[r_reg.sel];
                r_next.cnt = (AW+1)'(1);
                r_next.down = 1'b0;
                r_next.setMark = 1'b1;
                r_next.fillCnt = '0;
                r_next.st = ST_RD; // [R20]
              end else begin
                r_next.done = 1'b1;
              end
            end
            OP_FILTER: begin
              r_next.err = 1'b0;
              r_next.filt = cmdData[0];
              r_next.done = 1'b1;
            end
            default: r_next.err = 1'b1;
          endcase
        end
      end
      ST_FILL: begin
        wrEn = 1'b1;
        wrAddr = r_reg.fillAddr;
        wrData = {r_reg.fillMark, 3'b000, AMP_MID}; // [R15]
        r_next.fillMark = 1'b0;
        r_next.fillAddr = r_reg.fillAddr + 1'b1;
        r_next.fillCnt = r_reg.fillCnt - 1'b1;
        if (r_reg.fillCnt == (AW+1)'(1)) begin
          r_next.st = ST_IDLE;
          r_next.done = 1'b1;
        end
      end
      ST_RD: begin
        engAddr = r_reg.src;
        r_next.st = ST_WR;
      end
      ST_WR: begin
        wrEn = 1'b1;
        wrData = engData;
        if (r_reg.setMark) begin
          wrData[START_BIT] = 1'b1; // [R20]
        end
        r_next.src = r_reg.down ? r_reg.src - 1'b1 : r_reg.src + 1'b1;
        r_next.dst = r_reg.down ? r_reg.dst - 1'b1 : r_reg.dst + 1'b1;
        r_next.cnt = r_reg.cnt - 1'b1;
        r_next.st = ST_RD;
        if (r_reg.cnt == (AW+1)'(1)) begin
          r_next.st = (r_reg.fillCnt != '0) ? ST_FILL : ST_IDLE;
          r_next.done = (r_reg.fillCnt == '0);
        end
      end
      ST_GEN: begin
        p = r_reg.genHalf ? r_reg.genIdx[12:1] : r_reg.genIdx[11:0];
        wrEn = 1'b1;
        wrData = {r_reg.genHalf && r_reg.genIdx == '0, 3'b000, shape_val(r_reg.genShape, p)};
        r_next.dst = r_reg.dst + 1'b1;
        r_next.genIdx = r_reg.genIdx + 1'b1;
        r_next.cnt = r_reg.cnt - 1'b1;
        if (r_reg.cnt == (AW+1)'(1)) begin
          r_next.st = ST_IDLE;
          r_next.done = 1'b1;
        end
      end
      default: r_next.st = ST_IDLE;
    endcase

    // playback holds its last sample while the engine rewrites memory
    r_next.div = (r_reg.div == DIV_LAST) ? '0 : r_reg.div + 1'b1; // [R17]
    tick = (r_reg.st == ST_IDLE) && (r_reg.seq ? (r_reg.div == '0) : 1'b1);
    playAddr = r_reg.seq ? r_reg.dStart[r_reg.sel] + r_reg.playIdx[AW-1:0]
                         : FN_BASE + AW'(r_reg.phase[31:20]);
    if (r_reg.seq && !r_reg.dValid[r_reg.sel]) begin
      tick = 1'b0;
    end
    if (tick) begin
      if (r_reg.seq) begin
        r_next.playIdx = (r_reg.playIdx >= r_reg.dSize[r_reg.sel] - 1'b1) ? '0 : r_reg.playIdx + 1'b1; // [R6] [R7]
      end else begin
        r_next.phase = r_reg.phase + cwFreqWord; // [R5]
      end
    end
    r_next.tickD = tick;
    if (r_reg.tickD) begin
      r_next.amp = playData[AMP_W-1:0]; // [R3]
      r_next.mark = playData[START_BIT:ZAXIS_BIT]; // [R21] [R22]
      r_next.sync = r_reg.syncMk ? playData[START_BIT] : playData[AMP_W-1];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_reg <= '0;
      r_reg.st <= ST_GEN; // [R18]
      r_reg.dst <= FN_BASE;
      r_reg.cnt <= FN_PTS;
      r_reg.genShape <= SHAPE_SINE;
      r_reg.filt <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign cmdReady = (r_reg.st == ST_IDLE);
  assign cmdDone = r_reg.done;
  assign cmdError = r_reg.err;
  assign sampleCode = r_reg.amp;
  assign markerOut = r_reg.mark;
  assign syncOut = r_reg.sync;
  assign sequentialPlaybackMode = r_reg.seq;
  assign startMarkerSyncSource = r_reg.syncMk;
  assign filterEnable = r_reg.filt;
  assign usedPoints = r_reg.used;

endmodule : trace_memory_raster_player

// *** dv/trace_player_assertions.sv ***
/*
  port checks for the trace player.
  assumes one clock, sync high reset.
*/
`timescale 1ns/100ps
module trace_player_assertions
  import trace_player_pkg::*;
#(
  parameter int DEPTH = BASE_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmdValid,
  input wire logic cmdReady,
  input wire logic [3:0] cmdOp,
  input wire logic [$clog2(DEPTH):0] cmdSize,
  input wire logic cmdDone,
  input wire logic cmdError,
  input wire logic [AMP_W-1:0] sampleCode,
  input wire logic [3:0] markerOut,
  input wire logic syncOut,
  input wire logic sequentialPlaybackMode,
  input wire logic startMarkerSyncSource,
  input wire logic filterEnable,
  input wire logic [$clog2(DEPTH):0] usedPoints
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic take;
  logic [3:0] lastOp;
  logic [$clog2(DEPTH):0] takeSize;
  logic [$clog2(DEPTH):0] takeUsed;
  logic [12:0] upCnt;
  assign take = cmdValid && cmdReady;
  // cycles since reset, and the last command taken
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      upCnt <= 13'h0000;
      lastOp <= 4'h0;
      takeSize <= '0;
      takeUsed <= '0;
    end else begin
      if (upCnt != 13'h1fff) upCnt <= upCnt + 13'h0001;
      if (take) begin
        lastOp <= cmdOp;
        takeSize <= cmdSize;
        takeUsed <= usedPoints;
      end
    end
  end
  AST_RESET_STATE: assert property (upCnt < 13'h0fa0 |-> !cmdReady && usedPoints == '0 &&
    !sequentialPlaybackMode && filterEnable) else $error("reset state");
  AST_ONE_ANSWER: assert property (!(cmdDone && cmdError)) else $error("done with error");
  AST_SHORT_ANSWER: assert property (take && (cmdOp == OP_WR_POINT || cmdOp == OP_FILTER)
    |=> cmdDone || cmdError) else $error("no answer");
  AST_ERR_KEEPS: assert property (cmdError |-> usedPoints == takeUsed)
    else $error("refusal changed usage");
  AST_DEF_GROWS: assert property (cmdDone && lastOp == OP_DEF_SIZE |->
    usedPoints == takeUsed + takeSize) else $error("define size wrong");
  AST_DELETE_SHRINKS: assert property (cmdDone && lastOp == OP_DELETE |-> usedPoints < takeUsed)
    else $error("delete kept space");
  AST_REFUSE_FULL: assert property (take && cmdOp == OP_DEF_SIZE && cmdSize > DEPTH - usedPoints
    |=> cmdError) else $error("oversize taken");
  AST_SEL_USER: assert property (cmdDone && lastOp == OP_SEL_USER |-> sequentialPlaybackMode &&
    startMarkerSyncSource && !filterEnable) else $error("select modes");
  AST_SEL_FN: assert property (cmdDone && lastOp == OP_SEL_FN |-> !sequentialPlaybackMode)
    else $error("fn select mode");
  AST_SYNC_FOLLOWS: assert property ($stable(startMarkerSyncSource) && $stable(sequentialPlaybackMode)
    |-> syncOut == (startMarkerSyncSource ? markerOut[3] : sampleCode[11])) else $error("sync skew");
  cover property (take && cmdOp == OP_SEL_USER);
  cover property (cmdError);
  cover property (cmdDone && lastOp == OP_DELETE);
endmodule : trace_player_assertions

bind trace_memory_raster_player trace_player_assertions #(.DEPTH(DEPTH)) i_chk (
  .clk(clk), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp),
  .cmdSize(cmdSize), .cmdDone(cmdDone), .cmdError(cmdError), .sampleCode(sampleCode),
  .markerOut(markerOut), .syncOut(syncOut), .sequentialPlaybackMode(sequentialPlaybackMode),
  .startMarkerSyncSource(startMarkerSyncSource), .filterEnable(filterEnable), .usedPoints(usedPoints)
);

// *** dv/trace_host_model.sv ***
/*
  host model: one command at a time.
  assumes the ready/done/error handshake.
*/
`timescale 1ns/100ps
module trace_host_model
  import trace_player_pkg::*;
#(
  parameter int AW = 17
) (
  input wire logic clk,
  input wire logic cmdReady,
  input wire logic cmdDone,
  input wire logic cmdError,
  output logic cmdValid,
  output logic [3:0] cmdOp,
  output logic [5:0] cmdSlot,
  output logic [5:0] cmdSrc,
  output logic [AW:0] cmdSize,
  output logic [AW-1:0] cmdIndex,
  output logic [POINT_W-1:0] cmdData,
  output logic [31:0] cwFreqWord
);
  // records are picked by slot only, so no name ever reaches the port
  initial begin
    cmdValid = 1'b0;
    cmdOp = 4'h0;
    cmdSlot = 6'h00;
    cmdSrc = 6'h00;
    cmdSize = '0;
    cmdIndex = '0;
    cmdData = 16'h0000;
    cwFreqWord = 32'h0010_0000;
  end
  task automatic run(input logic [3:0] op, input logic [5:0] slot, input logic [5:0] src,
    input logic [AW:0] size, input logic [AW-1:0] idx, input logic [15:0] data, output logic err);
    int n;
    n = 0;
    @(negedge clk);
    while (!cmdReady && n < 40000) begin
      @(negedge clk);
      n++;
    end
    cmdValid = 1'b1;
    cmdOp = op;
    cmdSlot = slot;
    cmdSrc = src;
    cmdSize = size;
    cmdIndex = idx;
    cmdData = data;
    @(negedge clk);
    cmdValid = 1'b0;
    n = 0;
    while (!(cmdDone || cmdError) && n < 40000) begin
      @(negedge clk);
      n++;
    end
    err = (n < 40000) ? cmdError : 1'bx;
  endtask : run
  // toggling sync source rebuilds start marker
  task automatic restoreMarker(output logic err);
    logic e0;
    run(OP_SYNC_SRC, 6'h00, 6'h00, '0, '0, 16'h0000, e0);
    run(OP_SYNC_SRC, 6'h00, 6'h00, '0, '0, 16'h0001, err);
    err = err | e0;
  endtask : restoreMarker
endmodule : trace_host_model

// *** dv/test_trace_memory_raster_player.sv ***
/*
  bench for the trace player via the host model.
  assumes a 16384 point memory for a short run.
*/
`timescale 1ns/100ps
module test_trace_memory_raster_player;
  import trace_player_pkg::*;
  localparam int DEPTH = 16384;
  localparam int AW = 14;
  logic clk, sysRst, cmdValid, cmdReady, cmdDone, cmdError, syncOut, seqMode, syncMk, filterEn;
  logic [3:0] cmdOp, markerOut;
  logic [5:0] cmdSlot, cmdSrc;
  logic [AW:0] cmdSize, usedPoints;
  logic [AW-1:0] cmdIndex;
  logic [15:0] cmdData;
  logic [31:0] cwFreqWord;
  logic [11:0] sampleCode;
  int n_errors = 0;
  int checks = 0;
  trace_memory_raster_player #(.DEPTH(DEPTH)) i_dut (.clk(clk), .sys_rst(sysRst), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdSlot(cmdSlot), .cmdSrc(cmdSrc), .cmdSize(cmdSize),
    .cmdIndex(cmdIndex), .cmdData(cmdData), .cmdDone(cmdDone), .cmdError(cmdError), .cwFreqWord(cwFreqWord),
    .sampleCode(sampleCode), .markerOut(markerOut), .syncOut(syncOut), .sequentialPlaybackMode(seqMode),
    .startMarkerSyncSource(syncMk), .filterEnable(filterEn), .usedPoints(usedPoints));
  trace_host_model #(.AW(AW)) i_host (.clk(clk), .cmdReady(cmdReady), .cmdDone(cmdDone), .cmdError(cmdError),
    .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdSlot(cmdSlot), .cmdSrc(cmdSrc), .cmdSize(cmdSize),
    .cmdIndex(cmdIndex), .cmdData(cmdData), .cwFreqWord(cwFreqWord));
  task automatic chk(input string name, input logic [31:0] expv, input logic [31:0] got);
    checks++;
    if (got !== expv) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, expv, got);
    end
  endtask : chk
  task automatic doCmd(input logic [3:0] op, input int slot, input int src, input int size, input int idx,
    input logic [15:0] data, input logic expErr);
    logic err;
    i_host.run(op, slot[5:0], src[5:0], size[AW:0], idx[AW-1:0], data, err);
    chk("cmdError", {31'h0, expErr}, {31'h0, err});
  endtask : doCmd
  // each point shows for two clocks
  task automatic seqCheck(input logic [3:0] mk0);
    logic [11:0] ec [6] = '{12'h111, 12'h222, 12'h222, 12'h333, 12'h333, 12'h111};
    int n;
    n = 0;
    while (sampleCode !== 12'h333 && n < 60) begin
      @(negedge clk);
      n++;
    end
    while (sampleCode !== 12'h111 && n < 60) begin
      @(negedge clk);
      n++;
    end
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      chk("sampleCode", {20'h0, ec[i]}, {20'h0, sampleCode});
      chk("markerOut", ec[i] == 12'h111 ? mk0 : (ec[i] == 12'h222 ? 4'h2 : 4'h0), {28'h0, markerOut});
    end
  endtask : seqCheck
  task automatic note(input string name);
    $display("test %s done", name);
  endtask : note
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #600000;
    n_errors++;
    finish_test();
  end
  initial begin
    int n, nMark, nMid;
    int tOp [6] = '{1, 1, 4, 5, 15, 1};
    int tSlot [6] = '{50, 5, 2, 9, 0, 1};
    int tSize [6] = '{4, DEPTH, 0, 0, 0, 4};
    int tIdx [6] = '{0, 0, 6, 0, 0, 0};
    logic e;
    sysRst = 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    sysRst = 1'b0;
    n = 0;
    while (cmdReady !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    chk("seqMode", 0, seqMode);
    chk("syncMk", 0, syncMk);
    chk("filterEn", 1, filterEn);
    chk("usedPoints", 0, usedPoints);
    note("reset");
    doCmd(OP_DEF_SIZE, 0, 0, 5, 0, 16'h0000, 1'b0);
    doCmd(OP_SEL_USER, 0, 0, 0, 0, 16'h0000, 1'b0);
    chk("seqMode", 1, seqMode);
    chk("filterEn", 0, filterEn);
    repeat (10) @(negedge clk);
    nMark = 0;
    nMid = 0;
    // four passes of ten clocks
    repeat (40) begin
      @(negedge clk);
      nMark += int'(markerOut[3]);
      nMid += int'(sampleCode === AMP_MID);
    end
    chk("startMarks", 8, nMark);
    chk("midCodes", 40, nMid);
    note("define");
    doCmd(OP_DEF_SIZE, 1, 0, 3, 0, 16'h0000, 1'b0);
    chk("usedPoints", 8, usedPoints);
    doCmd(OP_WR_POINT, 1, 0, 0, 0, 16'h0111, 1'b0);
    doCmd(OP_WR_POINT, 1, 0, 0, 1, 16'h2222, 1'b0);
    doCmd(OP_WR_POINT, 1, 0, 0, 2, 16'h0333, 1'b0);
    doCmd(OP_SEL_USER, 1, 0, 0, 0, 16'h0000, 1'b0);
    seqCheck(4'h0);
    i_host.restoreMarker(e);
    chk("restoreErr", 0, e);
    seqCheck(4'h8);
    note("points");
    doCmd(OP_DEF_COPY_REC, 2, 1, 0, 0, 16'h0000, 1'b0);
    chk("usedPoints", 11, usedPoints);
    doCmd(OP_DELETE, 0, 0, 0, 0, 16'h0000, 1'b0);
    chk("usedPoints", 6, usedPoints);
    doCmd(OP_SEL_USER, 2, 0, 0, 0, 16'h0000, 1'b0);
    seqCheck(4'h8);
    doCmd(OP_RESIZE, 2, 0, 6, 0, 16'h0000, 1'b0);
    chk("usedPoints", 9, usedPoints);
    note("relocate");
    for (int i = 0; i < 6; i++) begin
      doCmd(tOp[i][3:0], tSlot[i], 0, tSize[i], tIdx[i], 16'h0000, 1'b1);
      chk("usedPoints", 9, usedPoints);
    end
    note("refuse");
    doCmd(OP_FILTER, 0, 0, 0, 0, 16'h0001, 1'b0);
    chk("filterEn", 1, filterEn);
    for (int s = 0; s < 4; s++) begin
      doCmd(OP_SEL_FN, 0, s, 0, 0, 16'h0000, 1'b0);
      chk("seqMode", 0, seqMode);
    end
    doCmd(OP_DEF_COPY_FN, 3, 0, 0, 0, 16'h0000, 1'b0);
    chk("usedPoints", 9 + COPY_FN_POINTS, usedPoints);
    doCmd(OP_DEF_SIZE, 4, 0, 5000, 0, 16'h0000, 1'b0);
    doCmd(OP_SEL_FN, 0, 0, 0, 0, 16'h0000, 1'b1);
    doCmd(OP_DEF_SIZE, 5, 0, DEPTH - 13200, 0, 16'h0000, 1'b1);
    doCmd(OP_DEF_SIZE, 5, 0, DEPTH - 13201, 0, 16'h0000, 1'b0);
    chk("usedPoints", DEPTH, usedPoints);
    doCmd(OP_DEF_SIZE, 6, 0, 1, 0, 16'h0000, 1'b1);
    note("builtin");
    finish_test();
  end
endmodule : test_trace_memory_raster_player
